// *** abhp_cfg.svh ***
// timing counts and field positions for the byte-wide converter host port
`ifndef ABHP_CFG_SVH
`define ABHP_CFG_SVH
`define ABHP_CTRL_EXT_ACQ_BIT  5      // control byte bit: 1 = external acquisition
`define ABHP_HOLD_FALL_EDGES   4'h4   // conversion-clock falls from write to hold
`define ABHP_CONV_CYCLES       4'ha   // conversion-clock cycles per result
`define ABHP_CLK_DIV           4'h8   // internal conversion clock divider
`define ABHP_RESULT_RESET      10'h000
`endif

// *** abhp_pkg.sv ***
// types for the byte-wide converter host port
package abhp_pkg;
	// conversion sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,   // waiting for a start
		ST_ACQ,    // internal acquisition, counting clock falls
		ST_TRACK,  // external acquisition, tracking until next write
		ST_CONV,   // successive approximation running
		ST_DONE    // result ready
	} abhp_state_t;
endpackage

// *** abhp_port.sv ***
// parallel host port, conversion sequencer and result bus of the converter
`timescale 1ns/1ps
`include "abhp_cfg.svh"

// Summary of operation
// - high select one: two result MSBs on bus
// - high select zero: eight result LSBs on bus
// - line 1 bit1/bit9, line 0 bit0/bit8
// - completion output low when result ready
// - select low, read fall starts bus drive
// - internal acquisition: write rise latches, acquires, converts
// - external acquisition: second write rise starts conversion
// - select high keeps bus high impedance
// - internal hold on fourth clock fall
// - external: track on write rise, hold next
// - read fall returns completion output high, except when conversion finishes in that cycle
module abhp_port (
	input  wire logic        clock_i,          // system clock, 125 MHz
	input  wire logic        srst_i,           // synchronous reset, active high
	input  wire logic        clk_en_i,         // freezes all state when low
	input  wire logic        chip_sel_n_i,     // chip select, active low
	input  wire logic        rd_n_i,           // read strobe, active low
	input  wire logic        wr_n_i,           // write strobe, active low
	input  wire logic        high_byte_select_i, // 1: MSBs, 0: LSBs
	input  wire logic        ext_clk_mode_i,   // 1: conversion clock from pin
	input  wire logic        conv_clk_pin_i,   // external conversion clock pin
	input  wire logic [9:0]  sample_i,         // digitised value from analog core
	input  wire logic [7:0]  data_in_i,        // bus lines as seen at the pins
	output logic      [7:0]  data_out_o,       // bus lines driven by the device
	output logic      [7:0]  data_oe_o,        // high while device drives a line
	output logic             done_n_o,         // completion flag, active low
	output logic             hold_o,           // track-and-hold in hold
	output logic      [7:0]  ctrl_byte_o       // last configuration byte latched
);

	// ----------------------------------------------------------------
	// pin edge detection
	// ----------------------------------------------------------------
	logic        rd_n_q, rd_n_d;        // previous read strobe
	logic        wr_n_q, wr_n_d;        // previous write strobe
	logic        cpin_q, cpin_d;        // previous external clock pin
	logic [3:0]  div_q, div_d;          // internal oscillator divider
	logic        rd_fall, wr_rise, cclk_fall;

	// strobe edges only count with chip select low
	assign rd_fall   = !chip_sel_n_i && rd_n_q && !rd_n_i;
	assign wr_rise   = !chip_sel_n_i && !wr_n_q && wr_n_i;
	// conversion clock fall from pin or internal divider wrap
	assign cclk_fall = ext_clk_mode_i ? (cpin_q && !conv_clk_pin_i)
	                                  : (div_q == `ABHP_CLK_DIV - 4'h1);

	// edge history next values
	always_comb begin
		rd_n_d = rd_n_i;
		wr_n_d = wr_n_i;
		cpin_d = conv_clk_pin_i;
		// internal oscillator: divider free-runs, pin is ignored (host ties it)
		div_d  = (div_q == `ABHP_CLK_DIV - 4'h1) ? 4'h0 : div_q + 4'h1;
	end

	// edge history registers
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			cpin_q <= 1'b0;
			div_q  <= 4'h0;
		end else if (clk_en_i) begin
			rd_n_q <= rd_n_d;
			wr_n_q <= wr_n_d;
			cpin_q <= cpin_d;
			div_q  <= div_d;
		end
	end

	// ----------------------------------------------------------------
	// conversion sequencer
	// ----------------------------------------------------------------
	abhp_pkg::abhp_state_t st_q, st_d;
	logic [3:0]  cnt_q, cnt_d;          // clock-fall counter
	logic [9:0]  res_q, res_d;          // output result
	logic [7:0]  ctl_q, ctl_d;          // configuration byte
	logic        done_q, done_d;        // result ready flag
	logic        rdact_q, rdact_d;      // read access in progress

	// next-state logic
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		res_d   = res_q;
		ctl_d   = ctl_q;
		done_d  = done_q;
		rdact_d = rdact_q;
		// read fall opens the bus and clears completion, unless ST_CONV finishes in the same cycle
		if (rd_fall) begin
			rdact_d = 1'b1;
			done_d  = 1'b0;
		end
		// access ends when read rises or select goes high
		if (rd_n_i || chip_sel_n_i)
			rdact_d = 1'b0;
		unique case (st_q)
			abhp_pkg::ST_IDLE, abhp_pkg::ST_DONE: begin
				if (wr_rise) begin
					ctl_d = data_in_i;
					cnt_d = 4'h0;
					if (data_in_i[`ABHP_CTRL_EXT_ACQ_BIT])
						st_d = abhp_pkg::ST_TRACK;
					else
						st_d = abhp_pkg::ST_ACQ;
				end
			end
			abhp_pkg::ST_ACQ: begin
				// hold on the fourth conversion-clock fall
				if (cclk_fall) begin
					if (cnt_q == `ABHP_HOLD_FALL_EDGES - 4'h1) begin
						cnt_d = 4'h0;
						st_d  = abhp_pkg::ST_CONV;
					end else
						cnt_d = cnt_q + 4'h1;
				end
			end
			abhp_pkg::ST_TRACK: begin
				// next write rise ends acquisition; data not latched again
				if (wr_rise) begin
					cnt_d = 4'h0;
					st_d  = abhp_pkg::ST_CONV;
				end
			end
			abhp_pkg::ST_CONV: begin
				if (cclk_fall) begin
					if (cnt_q == `ABHP_CONV_CYCLES - 4'h1) begin
						res_d  = sample_i;
						done_d = 1'b1;
						st_d   = abhp_pkg::ST_DONE;
					end else
						cnt_d = cnt_q + 4'h1;
				end
			end
			default: st_d = abhp_pkg::ST_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			st_q    <= abhp_pkg::ST_IDLE;
			cnt_q   <= 4'h0;
			res_q   <= `ABHP_RESULT_RESET;
			ctl_q   <= 8'h00;
			done_q  <= 1'b0;
			rdact_q <= 1'b0;
		end else if (clk_en_i) begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			res_q   <= res_d;
			ctl_q   <= ctl_d;
			done_q  <= done_d;
			rdact_q <= rdact_d;
		end
	end

	// ----------------------------------------------------------------
	// output bus
	// ----------------------------------------------------------------
	logic [7:0] bus_q, bus_d;           // registered data lines

	// byte multiplex of the held result
	always_comb begin
		if (high_byte_select_i)
			bus_d = {6'h00, res_q[9:8]};
		else
			bus_d = res_q[7:0];
	end

	// data outputs come from a flip-flop
	always_ff @(posedge clock_i) begin
		if (srst_i)
			bus_q <= 8'h00;
		else if (clk_en_i)
			bus_q <= bus_d;
	end

	assign data_out_o  = bus_q;
	// select high always releases the bus
	assign data_oe_o   = (rdact_q && !chip_sel_n_i) ? 8'hff : 8'h00;
	assign done_n_o    = !done_q;
	assign hold_o      = (st_q == abhp_pkg::ST_CONV);
	assign ctrl_byte_o = ctl_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	bus_released_a: assert property (@(posedge clock_i) disable iff (srst_i)
		chip_sel_n_i |-> data_oe_o == 8'h00)
		else $error("bus driven with select high");
	read_drive_a: assert property (@(posedge clock_i) disable iff (srst_i)
		(clk_en_i && rd_fall) ##1 (!rd_n_i && !chip_sel_n_i) |-> data_oe_o == 8'hff)
		else $error("read did not drive bus");
	high_byte_a: assert property (@(posedge clock_i) disable iff (srst_i)
		(clk_en_i && high_byte_select_i) |=> data_out_o == {6'h00, $past(res_q[9:8])})
		else $error("high byte wrong");
	low_byte_a: assert property (@(posedge clock_i) disable iff (srst_i)
		(clk_en_i && !high_byte_select_i) |=> data_out_o == $past(res_q[7:0]))
		else $error("low byte wrong");
	line_zero_a: assert property (@(posedge clock_i) disable iff (srst_i)
		clk_en_i |=> data_out_o[0] == ($past(high_byte_select_i) ? $past(res_q[8])
		                                                       : $past(res_q[0])))
		else $error("line zero wrong");
	done_low_a: assert property (@(posedge clock_i) disable iff (srst_i)
		(clk_en_i && st_q == abhp_pkg::ST_CONV && st_d == abhp_pkg::ST_DONE && !rd_fall)
		|=> !done_n_o)
		else $error("completion not flagged");
	done_clear_a: assert property (@(posedge clock_i) disable iff (srst_i)
		(clk_en_i && rd_fall && st_q != abhp_pkg::ST_CONV) |=> done_n_o)
		else $error("read did not clear completion");
	int_hold_a: assert property (@(posedge clock_i) disable iff (srst_i)
		(clk_en_i && st_q == abhp_pkg::ST_ACQ && cclk_fall
		 && cnt_q == `ABHP_HOLD_FALL_EDGES - 4'h1)
		|=> st_q == abhp_pkg::ST_CONV)
		else $error("hold not on fourth fall");
	ext_start_a: assert property (@(posedge clock_i) disable iff (srst_i)
		(clk_en_i && st_q == abhp_pkg::ST_TRACK && wr_rise) |=> hold_o)
		else $error("external start missed");
	int_latch_a: assert property (@(posedge clock_i) disable iff (srst_i)
		(clk_en_i && st_q == abhp_pkg::ST_IDLE && wr_rise
		 && !data_in_i[`ABHP_CTRL_EXT_ACQ_BIT])
		|=> st_q == abhp_pkg::ST_ACQ && ctrl_byte_o == $past(data_in_i))
		else $error("control byte not latched");

endmodule // abhp_port

// *** abhp_host_model.sv ***
// host side model: bus wire resolution and conversion clock pin
`timescale 1ns/1ps
module abhp_host_model (
	input  wire logic       clock_i,     // system clock
	input  wire logic       drive_en_i,  // host drives the bus
	input  wire logic [7:0] drive_val_i, // host bus value
	input  wire logic [7:0] dev_out_i,   // device bus value
	input  wire logic [7:0] dev_oe_i,    // device line enables
	input  wire logic       run_clk_i,   // pin clock running
	output logic      [7:0] bus_o,       // level seen on the wires
	output logic            conv_clk_o   // conversion clock pin
);
	logic [7:0] last_q = 8'h00; // last level, no pull on these lines
	logic [2:0] div_q  = 3'h0;  // pin clock divider
	// ---------------------------------------------
	// wire level
	// ---------------------------------------------
	// released lines flip every cycle so a stale value never reads as valid
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (dev_oe_i[i]) bus_o[i] = dev_out_i[i];
			else if (drive_en_i) bus_o[i] = drive_val_i[i];
			else bus_o[i] = ~last_q[i];
		end
	end
	// pin clock stands low when idle, one fall per eight cycles when run
	always_ff @(posedge clock_i) begin
		last_q <= bus_o;
		div_q  <= run_clk_i ? div_q + 3'h1 : 3'h0;
	end
	assign conv_clk_o = run_clk_i & div_q[2];
endmodule // abhp_host_model

// *** tb_top.sv ***
// self-checking bench of the converter host port
`timescale 1ns/1ps
module tb_top;
	logic clock_i = 0, srst_i = 1, cs_n = 1, rd_n = 1, wr_n = 1, hbs = 0, ext = 0;
	logic run = 0, drv = 0, en = 1, cclk, done_n, hold;
	logic [9:0] smp = 10'h2a5; // analog value
	logic [7:0] dval = 8'h00, bus, dout, doe, ctrl;
	int n_errors = 0, tests_run = 0;
	always #4 clock_i = ~clock_i;
	abhp_port abhp_port_inst (.clock_i(clock_i), .srst_i(srst_i), .clk_en_i(en),
		.chip_sel_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .high_byte_select_i(hbs),
		.ext_clk_mode_i(ext), .conv_clk_pin_i(cclk), .sample_i(smp), .data_in_i(bus),
		.data_out_o(dout), .data_oe_o(doe), .done_n_o(done_n), .hold_o(hold),
		.ctrl_byte_o(ctrl));
	abhp_host_model abhp_host_model_inst (.clock_i(clock_i), .drive_en_i(drv),
		.drive_val_i(dval), .dev_out_i(dout), .dev_oe_i(doe), .run_clk_i(run),
		.bus_o(bus), .conv_clk_o(cclk));
	// ---------------------------------------------
	// shared tasks
	// ---------------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bounded wait on hold (0) or done low (1)
	task automatic wait_for(input bit which);
		int k;
		for (k = 0; k < 400; k++) begin
			if ((which ? done_n : ~hold) === 1'b0) break;
			@(negedge clock_i);
		end
		if (k == 400) chk8(8'hee, 8'h00); // stuck wait counts as a mismatch
	endtask
	// write strobe, data held one cycle past the rise
	task automatic write_byte(input logic [7:0] b);
		cs_n = 0; drv = 1; dval = b; wr_n = 0;
		@(negedge clock_i) wr_n = 1;
		@(negedge clock_i) cs_n = 1;
		drv = 0;
		@(negedge clock_i) chk8(ctrl, b);
	endtask
	// read both bytes of the held result within one read
	task automatic read_both(input logic [9:0] v);
		cs_n = 0; hbs = 0; rd_n = 0;
		repeat (2) @(negedge clock_i);
		chk8(doe, 8'hff);
		chk8({7'h0, done_n}, 8'h01);
		chk8(dout, v[7:0]);
		hbs = 1;
		repeat (2) @(negedge clock_i);
		chk8(dout, {6'h00, v[9:8]});
		cs_n = 1;
		#1 chk8(doe, 8'h00);
		@(negedge clock_i) rd_n = 1;
		@(negedge clock_i);
	endtask
	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	// internal acquisition, internal clock
	task automatic internal_run();
		write_byte(8'h1c); // strobe then left high until the result
		repeat (20) @(negedge clock_i);
		chk8({7'h0, hold}, 8'h00);
		// fourth fall of an eight-cycle clock lands within 32 cycles of the write
		repeat (11) @(negedge clock_i);
		chk8({7'h0, hold}, 8'h01);
		// clock enable low must freeze the conversion well past its length
		en = 0;
		repeat (100) @(negedge clock_i);
		chk8({6'h0, hold, done_n}, 8'h03);
		en = 1;
		wait_for(1'b1);
		chk8({7'h0, done_n}, 8'h00);
		read_both(smp);
	endtask
	// external acquisition, pin clock
	task automatic external_run();
		ext = 1; run = 1; smp = 10'h15a;
		write_byte(8'h20);
		repeat (60) @(negedge clock_i);
		chk8({7'h0, hold}, 8'h00);
		cs_n = 0; wr_n = 0;
		@(negedge clock_i) wr_n = 1;
		repeat (3) @(negedge clock_i);
		cs_n = 1;
		chk8({7'h0, hold}, 8'h01);
		wait_for(1'b1);
		chk8({7'h0, done_n}, 8'h00);
		read_both(smp);
		run = 0;
	endtask
	// ---------------------------------------------
	// verdict
	// ---------------------------------------------
	task automatic complete_run();
		$display("errors=%0d compares=%0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge clock_i);
		srst_i = 0;
		@(negedge clock_i);
		internal_run();
		external_run();
		complete_run();
	end
	// watchdog, far beyond two conversions
	initial begin
		#40000;
		n_errors++;
		complete_run();
	end
endmodule // tb_top
